// [logic/driver_status_flags.sv]
/*
 * Driver status word: gathers standstill, chopper mode, current scale, temperature, open-load,
 * latched short-circuit and overtemperature indications and returns them on a register read.
 * Assumes all sense inputs are synchronous to core_clk_in and the serial front end supplies the 7-bit register address.
 */
// Behaviour
// [R01] Standstill bit after 2^20 idle clocks.
// [R02] Bit 30 shows quiet chopper active.
// [R03] Bits 20..16 return current scale.
// [R04] Bits 11..8 show temperature comparator levels.
// [R05] Open-load bits informational, no protective action.
// [R06] Software checks open load during slow motion.
// [R07] Low-side short sets bit 5/4, disables.
// [R08] Ground short sets bit 3/2, disables.
// [R09] Shorts latched until off-time zero or enable.
// [R10] Separate short flags per chopper mode.
// [R11] Overheat bit 1 disables until prewarn clears.
// [R12] Bit 0 shows shared prewarning.
// [R13] Word read-only, reserved bits read zero.
`timescale 1ns/1ps
module driver_status_flags
    import driver_status_pkg::*;
#(
    parameter int STANDSTILL_LIMIT = STANDSTILL_CYCLES
)(
    // Clock and reset
    input  wire logic                core_clk_in,
    input  wire logic                reset_n_in,
    // Register access
    input  wire logic                reg_read_in,
    input  wire logic                reg_write_in,
    input  wire logic [6:0]          reg_addr_in,
    input  wire logic [OFF_TIME_SETTING_W-1:0]   off_time_setting_in,
    input  wire logic                driver_enable_low_input_in,
    // Sensed driver state
    input  wire driver_sense_t       sense_in,
    // Read data
    output logic [STATUS_W-1:0]      read_data_out,
    output logic                     read_valid_out,
    // Driver control
    output logic                     bridge_disable_out
);

    logic         standstill;
    short_flags_t short_quiet_reg;
    short_flags_t short_quiet_next;
    short_flags_t short_curr_reg;
    short_flags_t short_curr_next;
    logic         overheat_hold_reg;
    logic         overheat_hold_next;
    logic [STATUS_W-1:0] data_reg;
    logic [STATUS_W-1:0] data_next;
    logic         valid_reg;
    logic         valid_next;
    logic         disable_reg;
    logic         disable_next;
    short_flags_t shown_short;
    logic         release_shorts;
    chop_mode_t   mode;

    // ------------------------------------------------------------------
    // Standstill timer
    // ------------------------------------------------------------------
    standstill_timer #(
        .LIMIT          (STANDSTILL_LIMIT)
    ) u_standstill (
        .core_clk_in    (core_clk_in),
        .reset_n_in     (reset_n_in),
        .step_in        (sense_in.step_pulse),
        .standstill_out (standstill)
    );

    // ------------------------------------------------------------------
    // Protection latches
    // ------------------------------------------------------------------
    always_comb
    begin
        mode           = sense_in.quiet_mode ? CHOP_QUIET : CHOP_CURRENT;
        release_shorts = (off_time_setting_in == OFF_TIME_SETTING_OFF) || driver_enable_low_input_in; // [R09]
        short_quiet_next = short_quiet_reg;
        short_curr_next  = short_curr_reg;
        if (release_shorts)
        begin
            short_quiet_next = '0; // [R09]
            short_curr_next  = '0;
        end
        else if (mode == CHOP_QUIET)
        begin
            short_quiet_next = short_quiet_reg | sense_in.short_detect; // [R07] [R08] [R10]
        end
        else
        begin
            short_curr_next = short_curr_reg | sense_in.short_detect; // [R10]
        end
        overheat_hold_next = overheat_hold_reg;
        if (sense_in.overheat)
        begin
            overheat_hold_next = 1'b1; // [R11]
        end
        else if (!sense_in.prewarn)
        begin
            overheat_hold_next = 1'b0; // [R11]
        end
        shown_short  = (mode == CHOP_QUIET) ? short_quiet_next : short_curr_next; // [R10]
        disable_next = (|shown_short) || overheat_hold_next; // [R05] [R07] [R08] [R11]
    end

    // ------------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------------
    always_comb
    begin
        data_next  = data_reg;
        valid_next = 1'b0;
        if (reg_read_in && (reg_addr_in == STATUS_ADDR))
        begin
            data_next                            = '0; // [R13]
            data_next[BIT_STANDSTILL]            = standstill; // [R01]
            data_next[BIT_QUIET_MODE]            = (mode == CHOP_QUIET); // [R02]
            data_next[CS_LSB +: CS_W]            = sense_in.current_scale; // [R03]
            data_next[TEMP_LSB +: TEMP_W]        = sense_in.temp_levels; // [R04]
            data_next[BIT_OPEN_B]                = sense_in.open_load_b; // [R05]
            data_next[BIT_OPEN_A]                = sense_in.open_load_a; // [R05]
            data_next[BIT_LS_B]                  = shown_short.lowside_short_phase_b; // [R07]
            data_next[BIT_LS_A]                  = shown_short.lowside_short_phase_a; // [R07]
            data_next[BIT_GND_B]                 = shown_short.ground_short_phase_b; // [R08]
            data_next[BIT_GND_A]                 = shown_short.ground_short_phase_a; // [R08]
            data_next[BIT_OVERHEAT]              = sense_in.overheat; // [R11]
            data_next[BIT_PREWARN]               = sense_in.prewarn; // [R12]
            valid_next                           = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Protection registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            short_quiet_reg   <= '0;
            short_curr_reg    <= '0;
            overheat_hold_reg <= 1'b0;
            disable_reg       <= 1'b0;
        end
        else
        begin
            short_quiet_reg   <= short_quiet_next;
            short_curr_reg    <= short_curr_next;
            overheat_hold_reg <= overheat_hold_next;
            disable_reg       <= disable_next;
        end
    end

    // ------------------------------------------------------------------
    // Status word registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            data_reg  <= '0;
            valid_reg <= 1'b0;
        end
        else
        begin
            data_reg  <= data_next;
            valid_reg <= valid_next;
        end
    end

    assign read_data_out      = data_reg;
    assign read_valid_out     = valid_reg;
    assign bridge_disable_out = disable_reg;

endmodule : driver_status_flags

// [logic/driver_status_pkg.sv]
/*
 * Package for the driver status word: register index, bit positions, field widths and timing counts.
 * Assumes a single core clock at 40 MHz shared by every user of the package.
 */
package driver_status_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [6:0] STATUS_ADDR     = 7'h6F;
    localparam int         STATUS_W        = 32;

    // ------------------------------------------------------------------
    // Bit positions
    // ------------------------------------------------------------------
    localparam int BIT_STANDSTILL = 31;
    localparam int BIT_QUIET_MODE = 30;
    localparam int CS_LSB         = 16;
    localparam int CS_W           = 5;
    localparam int TEMP_LSB       = 8;
    localparam int TEMP_W         = 4;
    localparam int BIT_OPEN_B     = 7;
    localparam int BIT_OPEN_A     = 6;
    localparam int BIT_LS_B       = 5;
    localparam int BIT_LS_A       = 4;
    localparam int BIT_GND_B      = 3;
    localparam int BIT_GND_A      = 2;
    localparam int BIT_OVERHEAT   = 1;
    localparam int BIT_PREWARN    = 0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int STANDSTILL_LOG2   = 20;
    localparam int STANDSTILL_CYCLES = 1 << STANDSTILL_LOG2;
    localparam int OFF_TIME_SETTING_W            = 4;
    localparam logic [3:0] OFF_TIME_SETTING_OFF  = 4'h0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic {
        CHOP_CURRENT,
        CHOP_QUIET
    } chop_mode_t;

    typedef struct packed {
        logic lowside_short_phase_b;
        logic lowside_short_phase_a;
        logic ground_short_phase_b;
        logic ground_short_phase_a;
    } short_flags_t;

    typedef struct packed {
        logic            step_pulse;
        logic            quiet_mode;
        logic [CS_W-1:0] current_scale;
        logic [TEMP_W-1:0] temp_levels;
        logic            open_load_b;
        logic            open_load_a;
        short_flags_t    short_detect;
        logic            overheat;
        logic            prewarn;
    } driver_sense_t;

endpackage : driver_status_pkg

// [logic/standstill_timer.sv]
/*
 * Counts clocks since the last step pulse and raises a standstill level once the limit is reached.
 * Assumes the step pulse is synchronous to the core clock.
 */
`timescale 1ns/1ps
module standstill_timer
    import driver_status_pkg::*;
#(
    parameter int LIMIT = STANDSTILL_CYCLES
)(
    // Clock and reset
    input  wire logic core_clk_in,
    input  wire logic reset_n_in,
    // Step activity
    input  wire logic step_in,
    // Standstill level
    output logic      standstill_out
);

    localparam int CNT_W = $clog2(LIMIT + 1);
    localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(LIMIT);

    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic             stand_reg;
    logic             stand_next;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        count_next = count_reg;
        stand_next = stand_reg;
        if (step_in)
        begin
            count_next = '0;
            stand_next = 1'b0;
        end
        else if (count_reg != CNT_MAX)
        begin
            count_next = count_reg + CNT_W'(1);
            stand_next = (count_reg + CNT_W'(1)) == CNT_MAX;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            count_reg <= '0;
            stand_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            stand_reg <= stand_next;
        end
    end

    assign standstill_out = stand_reg;

endmodule : standstill_timer

// [verification/driver_status_flags_tb_top.sv]
/* Self-checking bench for the driver status word.
 * Assumes the design package is compiled first. */
`timescale 1ns/1ps
`define CHECK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module driver_status_flags_tb_top;
    import driver_status_pkg::*;
    logic core_clk_in = 1'b0, reset_n_in = 1'b0, driver_enable_low_input = 1'b0, rd, wr, ok, brg, vld;
    logic [6:0] addr;
    logic [3:0] off_time_setting = 4'h5;
    logic [31:0] rdat, d;
    driver_sense_t sense = '0;
    int fail_count = 0, checked = 0;
    always #12.5 core_clk_in = ~core_clk_in;
    driver_status_flags #(.STANDSTILL_LIMIT(16)) u_driver_status_flags (.core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in), .reg_read_in(rd), .reg_write_in(wr), .reg_addr_in(addr),
        .off_time_setting_in(off_time_setting), .driver_enable_low_input_in(driver_enable_low_input), .sense_in(sense),
        .read_data_out(rdat), .read_valid_out(vld), .bridge_disable_out(brg));
    status_host u_status_host (.core_clk_in(core_clk_in), .reg_read_out(rd), .reg_write_out(wr),
        .reg_addr_out(addr), .read_data_in(rdat), .read_valid_in(vld));
    task tick(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask : tick
    task finish_test;
        $display("checked %0d, wrong %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test
    initial
    begin
        repeat (20000) @(posedge core_clk_in);
        fail_count++;
        finish_test();
    end
    initial
    begin
        repeat (16) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        // Field pass-through; open-load bits are information only and leave the bridge enabled.
        for (int i = 0; i < 4; i++)
        begin
            sense.quiet_mode <= i[0];
            sense.current_scale <= 5'h1F - 5'(i * 10);
            sense.temp_levels <= 4'h1 << i;
            {sense.open_load_b, sense.open_load_a} <= i[1:0];
            sense.prewarn <= i[0];
            tick(20);
            u_status_host.read_word(7'h6F, d, ok);
            `CHECK(ok, 1'b1)
            `CHECK(d, {1'b1, i[0], 9'h000, 5'h1F - 5'(i * 10), 4'h0, 4'h1 << i, i[1:0], 4'h0, 1'b0, i[0]})
            `CHECK(brg, 1'b0)
        end
        $display("field test done");
        sense.step_pulse <= 1'b1;
        tick(1);
        sense.step_pulse <= 1'b0;
        u_status_host.read_word(7'h6F, d, ok);
        `CHECK(d[31], 1'b0)
        tick(20);
        u_status_host.read_word(7'h6F, d, ok);
        `CHECK(d[31], 1'b1)
        u_status_host.write_word(7'h6F);
        u_status_host.read_word(7'h6F, d, ok);
        `CHECK(d, 32'hC00108C1)
        u_status_host.read_word(7'h6E, d, ok);
        `CHECK(ok, 1'b0)
        $display("standstill and access test done");
        for (int m = 0; m < 2; m++)
            for (int b = 0; b < 4; b++)
            begin
                sense.quiet_mode <= m[0];
                tick(3);
                sense.short_detect <= short_flags_t'(4'h1 << b);
                tick(1);
                sense.short_detect <= '0;
                tick(3);
                u_status_host.read_word(7'h6F, d, ok);
                `CHECK(d[5:2], 4'(1 << b))
                `CHECK(brg, 1'b1)
                sense.quiet_mode <= ~m[0];
                tick(3);
                u_status_host.read_word(7'h6F, d, ok);
                `CHECK({d[5:2], brg}, 5'h00)
                sense.quiet_mode <= m[0];
                tick(3);
                `CHECK(brg, 1'b1)
                if (b[0])
                    driver_enable_low_input <= 1'b1;
                else
                    off_time_setting <= 4'h0;
                tick(3);
                driver_enable_low_input <= 1'b0;
                off_time_setting <= 4'h5;
                tick(3);
                u_status_host.read_word(7'h6F, d, ok);
                `CHECK({d[5:2], brg}, 5'h00)
            end
        $display("short test done");
        sense.overheat <= 1'b1;
        sense.prewarn <= 1'b1;
        tick(3);
        `CHECK(brg, 1'b1)
        sense.overheat <= 1'b0;
        tick(3);
        `CHECK(brg, 1'b1)
        sense.prewarn <= 1'b0;
        tick(3);
        `CHECK(brg, 1'b0)
        $display("overheat test done");
        finish_test();
    end
endmodule : driver_status_flags_tb_top

// [verification/driver_status_monitor.sv]
/* Port checker for the driver status word.
 * Assumes it is bound to every instance of driver_status_flags. */
`timescale 1ns/1ps
module driver_status_monitor
    import driver_status_pkg::*;
(
    // Clock, reset and access
    input wire logic                core_clk_in,
    input wire logic                reset_n_in,
    input wire logic                reg_read_in,
    input wire logic [6:0]          reg_addr_in,
    // Sense and outputs
    input wire driver_sense_t       sense_in,
    input wire logic [STATUS_W-1:0] read_data_out,
    input wire logic                read_valid_out,
    input wire logic                bridge_disable_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    chk_read_answer: assert property (reg_read_in && reg_addr_in == STATUS_ADDR |=> read_valid_out)
        else $error("status read not answered");
    chk_no_answer: assert property (!(reg_read_in && reg_addr_in == STATUS_ADDR) |=> !read_valid_out)
        else $error("answer without status read");
    chk_data_hold: assert property (!read_valid_out |-> $stable(read_data_out))
        else $error("read data moved without a read");
    chk_reserved_zero: assert property (read_valid_out |->
        read_data_out[29:21] == 9'h000 && read_data_out[15:12] == 4'h0)
        else $error("reserved bits set");
    chk_mode_bit: assert property (read_valid_out |-> read_data_out[30] == $past(sense_in.quiet_mode))
        else $error("chopper mode bit wrong");
    chk_scale_temp: assert property (read_valid_out |->
        read_data_out[20:16] == $past(sense_in.current_scale) && read_data_out[11:8] == $past(sense_in.temp_levels))
        else $error("scale or temperature bits wrong");
    chk_heat_bits: assert property (read_valid_out |->
        read_data_out[1:0] == {$past(sense_in.overheat), $past(sense_in.prewarn)})
        else $error("overheat bits wrong");
    chk_overheat_off: assert property (sense_in.overheat |-> ##[1:2] bridge_disable_out)
        else $error("overheat did not disable bridge");
    chk_short_off: assert property (read_valid_out && (|read_data_out[5:2]) |-> bridge_disable_out)
        else $error("shown short did not disable bridge");
    chk_step_clears: assert property (read_valid_out &&
        ($past(sense_in.step_pulse, 2) || $past(sense_in.step_pulse, 3)) |-> !read_data_out[31])
        else $error("standstill not cleared by step");
endmodule : driver_status_monitor

bind driver_status_flags driver_status_monitor u_driver_status_monitor (.core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in), .reg_read_in(reg_read_in), .reg_addr_in(reg_addr_in), .sense_in(sense_in),
    .read_data_out(read_data_out), .read_valid_out(read_valid_out), .bridge_disable_out(bridge_disable_out));

// [verification/status_host.sv]
/* Host model issuing status reads and writes on the strobe and address ports.
 * Assumes a one-cycle answer after each accepted read. */
`timescale 1ns/1ps
module status_host (
    // Clock
    input wire logic        core_clk_in,
    // Access strobes
    output logic            reg_read_out  = 1'b0,
    output logic            reg_write_out = 1'b0,
    output logic [6:0]      reg_addr_out  = 7'h00,
    // Answer
    input wire logic [31:0] read_data_in,
    input wire logic        read_valid_in
);
    task read_word(input logic [6:0] a, output logic [31:0] d, output logic ok);
        @(posedge core_clk_in);
        reg_read_out <= 1'b1;
        reg_addr_out <= a;
        @(posedge core_clk_in);
        reg_read_out <= 1'b0;
        #1;
        ok = read_valid_in;
        d  = read_data_in;
    endtask : read_word
    task write_word(input logic [6:0] a);
        @(posedge core_clk_in);
        reg_write_out <= 1'b1;
        reg_addr_out  <= a;
        @(posedge core_clk_in);
        reg_write_out <= 1'b0;
    endtask : write_word
endmodule : status_host
